// File: hdl/gtc_timer.sv
// sixteen bit gated timer/counter with prescaler, reached over apb
// assumes pins are asynchronous to core_clk; syncedComparatorOut is already on core_clk
`timescale 1ns/1ps
`include "gtc_defines.svh"
//
// How it works
// - sixteen bit count, both bytes read/write
// - timer mode counts every instruction cycle
// - counter mode counts external rising edges
// - falling edge needed before first counted rise
// - rollover sets overflow flag bit zero
// - prescaler divides by one, two, four, eight
// - prescaler hidden, cleared on count write
// - gate source is pin or comparator
// - comparator gate uses synchronised output
// - gate enable ignored while timer off
// - gate invert selects high or low true
// - low power oscillator clocks when allowed
// - sync bit ignored for internal clock
// - clock select external edges or fosc/4
// - asynchronous mode counts and wakes in sleep
// - control bits reset zero, read/write
// - count reads valid while running asynchronously
module gtc_timer
  import gtc_pkg::*;
#(
  parameter int PRESCALE_BITS = 3
)
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`GTC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  input  wire logic                   extClockPin,
  input  wire logic                   lowPowerOscPin,
  input  wire logic                   gatePin,
  input  wire logic                   syncedComparatorOut,
  input  wire logic                   oscShareOk,
  input  wire logic                   sleepMode,
  output      logic                   overflowFlag,
  output      logic                   wakeRequest,
  output      logic                   lowPowerOscOn
);
  if (PRESCALE_BITS != 3)
  begin : gBadPrescale
    $error("prescaler must be three bits wide for the 1:8 setting");
  end

  // apb side
  logic       setup;
  logic       access;
  logic       wrAccess;
  logic       mapped;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic       slvErr_q;
  logic       slvErr_d;

  // software state
  gtc_byte_t  ctl_q;
  gtc_byte_t  ctl_d;
  logic       gss_q;
  logic       gss_d;
  logic       ovf_q;
  logic       ovf_d;
  gtc_count_t count_q;
  gtc_count_t count_d;
  logic [PRESCALE_BITS-1:0] psc_q;
  logic [PRESCALE_BITS-1:0] psc_d;

  // sampling and timing
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic       pend_q;
  logic       pend_d;
  logic [1:0] extSync_q;
  logic [1:0] lpSync_q;
  logic [1:0] gateSync_q;

  logic       wrLow;
  logic       wrHigh;
  logic       cntWr;
  logic       instrTick;
  logic       oscActive;
  gtc_src_e   src;
  logic       bypass;
  logic       gateRaw;
  logic       gateTrue;
  logic       run;
  logic       countTick;
  logic       inc;
  logic       rollover;
  logic [PRESCALE_BITS-1:0] pscMask;

  gtc_edge_if edgeBus ();

  gtc_edge_arm u_edge (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .edge_port (edgeBus.arm)
  );

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign pready   = access;
  assign wrAccess = access && pwrite;
  assign mapped   = (paddr == `GTC_OFF_COUNT_LOW) || (paddr == `GTC_OFF_COUNT_HIGH) ||
                    (paddr == `GTC_OFF_FLAGS) || (paddr == `GTC_OFF_GATE_CFG) ||
                    (paddr == `GTC_OFF_CONTROL);
  assign wrLow    = wrAccess && (paddr == `GTC_OFF_COUNT_LOW);
  assign wrHigh   = wrAccess && (paddr == `GTC_OFF_COUNT_HIGH);
  assign cntWr    = wrLow || wrHigh;
  assign prdata   = prdata_q;
  assign pslverr  = slvErr_q && access;

  // pins pass two flops; only the second stage feeds any logic
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      extSync_q  <= 2'h0;
      lpSync_q   <= 2'h0;
      gateSync_q <= 2'h0;
    end
    else
    begin
      extSync_q  <= {extSync_q[0], extClockPin};
      lpSync_q   <= {lpSync_q[0], lowPowerOscPin};
      gateSync_q <= {gateSync_q[0], gatePin};
    end
  end

  assign instrTick = (phase_q == 2'(`GTC_FOSC_DIV - 1));
  assign oscActive = ctl_q[`GTC_CTL_OSCEN] && oscShareOk;
  assign lowPowerOscOn = oscActive;
  assign src       = ctl_q[`GTC_CTL_CS] ? GTC_SRC_EXTERNAL : GTC_SRC_INTERNAL;
  assign bypass    = ctl_q[`GTC_CTL_SYNC] && (src == GTC_SRC_EXTERNAL);

  assign edgeBus.level    = oscActive ? lpSync_q[1] : extSync_q[1];
  assign edgeBus.clear    = cntWr;
  assign edgeBus.timerOff = !ctl_q[`GTC_CTL_ON];

  // comparator output already lives on core_clk, so it takes no extra stages
  assign gateRaw  = gss_q ? syncedComparatorOut : gateSync_q[1];
  assign gateTrue = ctl_q[`GTC_CTL_GINV] ? gateRaw : !gateRaw;
  assign run      = ctl_q[`GTC_CTL_ON] && (!ctl_q[`GTC_CTL_GE] || gateTrue);

  // the instruction clock stops in sleep; only the bypassed external path keeps going
  always_comb
  begin
    countTick = 1'b0;
    if (src == GTC_SRC_INTERNAL)
    begin
      countTick = instrTick && !sleepMode;
    end
    else if (bypass)
    begin
      countTick = edgeBus.rise;
    end
    else
    begin
      countTick = pend_q && instrTick && !sleepMode;
    end
  end

  always_comb
  begin
    unique case (ctl_q[`GTC_CTL_PS_HI:`GTC_CTL_PS_LO])
      2'b00: pscMask = 3'h0;
      2'b01: pscMask = 3'h1;
      2'b10: pscMask = 3'h3;
      2'b11: pscMask = 3'h7;
    endcase
  end

  assign inc      = run && countTick && (psc_q == pscMask) && !cntWr;
  assign rollover = inc && (count_q == `GTC_COUNT_MAX);
  assign overflowFlag = ovf_q;
  assign wakeRequest  = ovf_q && sleepMode;

  always_comb
  begin
    phase_d = phase_q + 2'h1;
    pend_d  = pend_q;
    if (src == GTC_SRC_EXTERNAL && !bypass)
    begin
      if (instrTick)
        pend_d = 1'b0;
      if (edgeBus.rise)
        pend_d = 1'b1;
    end
    else
    begin
      pend_d = 1'b0;
    end
  end

  always_comb
  begin
    ctl_d   = ctl_q;
    gss_d   = gss_q;
    ovf_d   = ovf_q;
    count_d = count_q;
    psc_d   = psc_q;
    if (wrAccess && paddr == `GTC_OFF_CONTROL)
      ctl_d = pwdata[7:0];
    if (wrAccess && paddr == `GTC_OFF_GATE_CFG)
      gss_d = pwdata[`GTC_CFG_GSS];
    if (wrAccess && paddr == `GTC_OFF_FLAGS)
      ovf_d = pwdata[`GTC_FLAG_OVF];
    if (rollover)
      ovf_d = 1'b1;
    if (wrLow)
    begin
      count_d[7:0] = pwdata[7:0];
      psc_d        = '0;
    end
    else if (wrHigh)
    begin
      count_d[15:8] = pwdata[7:0];
      psc_d         = '0;
    end
    else if (run && countTick)
    begin
      psc_d = (psc_q == pscMask) ? '0 : psc_q + 3'h1;
      if (inc)
        count_d = count_q + 16'h0001;
    end
  end

  // read data is captured in the setup cycle so it stands for the whole access phase
  always_comb
  begin
    prdata_d = prdata_q;
    slvErr_d = 1'b0;
    if (setup)
    begin
      slvErr_d = !mapped;
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        `GTC_OFF_COUNT_LOW:  prdata_d[7:0] = count_q[7:0];
        `GTC_OFF_COUNT_HIGH: prdata_d[7:0] = count_q[15:8];
        `GTC_OFF_FLAGS:      prdata_d[`GTC_FLAG_OVF] = ovf_q;
        `GTC_OFF_GATE_CFG:   prdata_d[`GTC_CFG_GSS] = gss_q;
        `GTC_OFF_CONTROL:    prdata_d[7:0] = ctl_q;
        default:             prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_q    <= `GTC_CTL_RESET;
      gss_q    <= `GTC_CFG_RESET;
      ovf_q    <= 1'b0;
      count_q  <= 16'h0000;
      psc_q    <= '0;
      phase_q  <= 2'h0;
      pend_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
      slvErr_q <= 1'b0;
    end
    else
    begin
      ctl_q    <= ctl_d;
      gss_q    <= gss_d;
      ovf_q    <= ovf_d;
      count_q  <= count_d;
      psc_q    <= psc_d;
      phase_q  <= phase_d;
      pend_q   <= pend_d;
      prdata_q <= prdata_d;
      slvErr_q <= slvErr_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence instrGap;
    !instrTick [*3] ##1 instrTick;
  endsequence

  ctlWrite_a: assert property (wrAccess && paddr == `GTC_OFF_CONTROL |=>
    ctl_q == $past(pwdata[7:0]))
    else $error("control write not stored");
  lowWrite_a: assert property (wrLow |=> count_q[7:0] == $past(pwdata[7:0]) &&
    $stable(count_q[15:8]))
    else $error("low count byte write wrong");
  ovfSet_a: assert property (inc && count_q == `GTC_COUNT_MAX |=>
    ovf_q && count_q == 16'h0000)
    else $error("rollover did not set flag");
  holdOff_a: assert property (!run && !cntWr |=> $stable(count_q) && $stable(psc_q))
    else $error("stopped timer changed state");
  pscClear_a: assert property (cntWr |=> psc_q == '0)
    else $error("count write left prescaler");
  instrSpace_a: assert property (instrTick |=> instrGap)
    else $error("instruction tick not every four clocks");
  gateHold_a: assert property (ctl_q[`GTC_CTL_ON] && ctl_q[`GTC_CTL_GE] && !gateTrue |->
    !inc)
    else $error("count advanced while gate false");
  prescale8_a: assert property (ctl_q[`GTC_CTL_PS_HI:`GTC_CTL_PS_LO] == 2'b11 && run &&
    countTick && !cntWr && psc_q != 3'h7 |=> psc_q == $past(psc_q) + 3'h1 && $stable(count_q))
    else $error("1:8 prescaler counted early");
  sleepStop_a: assert property (sleepMode && !bypass |-> !countTick)
    else $error("count ticked in sleep without bypass");
  errMap_a: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped address not refused");
endmodule // gtc_timer

// File: hdl/gtc_defines.svh
// register offsets, field positions, reset values and timing counts of the gated timer
// assumes a 32-bit apb slave with byte addresses and one register per aligned word
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

`define GTC_ADDR_W         8
`define GTC_OFF_COUNT_LOW  8'h00
`define GTC_OFF_COUNT_HIGH 8'h04
`define GTC_OFF_FLAGS      8'h08
`define GTC_OFF_GATE_CFG   8'h0C
`define GTC_OFF_CONTROL    8'h10

`define GTC_CTL_ON         0
`define GTC_CTL_CS         1
`define GTC_CTL_SYNC       2
`define GTC_CTL_OSCEN      3
`define GTC_CTL_PS_LO      4
`define GTC_CTL_PS_HI      5
`define GTC_CTL_GE         6
`define GTC_CTL_GINV       7
`define GTC_FLAG_OVF       0
`define GTC_CFG_GSS        0

`define GTC_CTL_RESET      8'h00
`define GTC_CFG_RESET      1'b0
`define GTC_COUNT_MAX      16'hFFFF

`define GTC_CLK_PERIOD_NS  5
`define GTC_FOSC_DIV       4

`endif

// File: hdl/gtc_pkg.sv
// types shared by the gated timer modules
// assumes gtc_defines.svh supplies the numeric constants
package gtc_pkg;
  typedef logic [7:0]  gtc_byte_t;
  typedef logic [15:0] gtc_count_t;
  typedef enum logic { GTC_SRC_INTERNAL, GTC_SRC_EXTERNAL } gtc_src_e;
endpackage

// File: hdl/gtc_edge_if.sv
// carries the selected external clock level to the edge arming logic and its rising edge back
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface gtc_edge_if;
  logic level;
  logic clear;
  logic timerOff;
  logic rise;
  modport arm  (input level, input clear, input timerOff, output rise);
  modport user (output level, output clear, output timerOff, input rise);
endinterface

// File: hdl/gtc_edge_arm.sv
// rising edge detector that must see a falling edge before it reports the first rise
// assumes level is already synchronised to core_clk
`timescale 1ns/1ps
module gtc_edge_arm
  import gtc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  gtc_edge_if.arm   edge_port
);
  logic prev_q;
  logic prev_d;
  logic armed_q;
  logic armed_d;

  always_comb
  begin
    prev_d  = edge_port.level;
    armed_d = armed_q;
    if (edge_port.clear)
    begin
      armed_d = 1'b0;
    end
    else if (edge_port.timerOff && edge_port.level)
    begin
      armed_d = 1'b0;
    end
    // a fall while stopped does not arm: it must be seen while the timer runs
    else if (!edge_port.timerOff && prev_q && !edge_port.level)
    begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
    end
  end

  // an unarmed detector never reports a rise, so a count write restarts the edge hunt
  assign edge_port.rise = edge_port.level && !prev_q && armed_q && !edge_port.clear;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  riseArmed_a: assert property (edge_port.rise |-> $past(edge_port.level) == 1'b0 && armed_q)
    else $error("rise reported without prior falling edge");
endmodule // gtc_edge_arm

// File: test/gtc_pin_model.sv
// pin-side partner of the gated timer: external clock, low-power osc, gate pin, comparator
// assumes pulses() is called just after a rising core_clk edge
`timescale 1ns/1ps
module gtc_pin_model
(
  input  wire logic core_clk,
  output      logic extClockPin,
  output      logic lowPowerOscPin,
  output      logic gatePin,
  output      logic syncedComparatorOut
);
  // clocks stand still low between bursts; gate false, comparator true
  initial
  begin
    extClockPin = 1'b0;
    lowPowerOscPin = 1'b0;
    gatePin = 1'b0;
    syncedComparatorOut = 1'b1;
  end

  // each level held 4 cycles, above the 2 the synchroniser needs
  task automatic pulses(input int n);
    repeat (n)
    begin
      extClockPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      extClockPin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  // leaves the external clock at one level, to stop the timer while the pin is high
  task automatic setLevel(input logic v);
    extClockPin <= v;
  endtask

  task automatic lpPulses(input int n);
    repeat (n)
    begin
      lowPowerOscPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      lowPowerOscPin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule // gtc_pin_model

// File: test/gtc_timer_tb_top.sv
// self-checking bench for the gated timer: apb tasks, pin model, table of timed runs
// assumes a 200 MHz core clock and a four-cycle instruction tick
`timescale 1ns/1ps
`include "gtc_defines.svh"
module gtc_timer_tb_top
  import gtc_pkg::*;
  ;
  logic                   core_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [`GTC_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   oscShareOk = 1'b0;
  logic                   sleepMode = 1'b0;
  logic                   extClockPin;
  logic                   lowPowerOscPin;
  logic                   gatePin;
  logic                   syncedComparatorOut;
  logic                   overflowFlag;
  logic                   wakeRequest;
  logic                   lowPowerOscOn;
  int                     errCount = 0;
  int                     comparisons = 0;
  logic [31:0]            rd;
  logic                   er;
  // prescale, gate source, polarity and enable rows; 64 cycles = 16 ticks each
  localparam logic [7:0] CTL [9] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'hC1,
                                     8'h41, 8'h81, 8'hC1, 8'h41};
  localparam logic [7:0] EXV [9] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h00,
                                     8'h10, 8'h10, 8'h10, 8'h00};

  always #2.5 core_clk = ~core_clk;

  gtc_timer #(.PRESCALE_BITS(3)) dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .extClockPin, .lowPowerOscPin, .gatePin,
    .syncedComparatorOut, .oscShareOk, .sleepMode, .overflowFlag, .wakeRequest,
    .lowPowerOscOn);

  gtc_pin_model pm (.core_clk, .extClockPin, .lowPowerOscPin, .gatePin, .syncedComparatorOut);

  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // setup cycle, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel in this time step
    @(posedge core_clk);
    if (n >= 16)
    begin
      errCount++;
      tallyAndFinish();
    end
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(what, {24'h000000, exp}, rd);
  endtask

  task automatic setCount(input logic [15:0] v);
    xfer(1'b1, `GTC_OFF_COUNT_LOW, v[7:0]);
    xfer(1'b1, `GTC_OFF_COUNT_HIGH, v[15:8]);
  endtask

  task automatic chkCount(input logic [15:0] v);
    rdChk("countLow", `GTC_OFF_COUNT_LOW, v[7:0]);
    rdChk("countHigh", `GTC_OFF_COUNT_HIGH, v[15:8]);
  endtask

  // enable-to-disable spacing is w+2 edges
  task automatic run(input logic [7:0] ctl, input int w);
    xfer(1'b1, `GTC_OFF_CONTROL, ctl);
    repeat (w - 1) @(posedge core_clk);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdChk("control", `GTC_OFF_CONTROL, `GTC_CTL_RESET);
    chkCount(16'h0000);
    xfer(1'b0, 8'h14, 8'h00);
    chk("unmappedErr", 32'h1, {31'h0, er});
    chk("unmappedData", 32'h0, rd);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'hFF);
    rdChk("control", `GTC_OFF_CONTROL, 8'hFF);
    chk("oscOff", 32'h0, {31'h0, lowPowerOscOn});
    oscShareOk <= 1'b1;
    @(posedge core_clk);
    chk("oscOn", 32'h1, {31'h0, lowPowerOscOn});
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 9; i++)
    begin
      setCount(16'h0000);
      xfer(1'b1, `GTC_OFF_GATE_CFG, {7'h00, i > 6});
      run(CTL[i], 62);
      chkCount({8'h00, EXV[i]});
    end
    $display("test timer table done");
    setCount(16'h0000);
    run(8'h31, 18);
    setCount(16'h0000);
    run(8'h31, 10);
    chkCount(16'h0000);
    setCount(16'hFFFF);
    run(8'h01, 18);
    chkCount(16'h0004);
    rdChk("flag", `GTC_OFF_FLAGS, 8'h01);
    chk("flagPin", 32'h1, {31'h0, overflowFlag});
    xfer(1'b1, `GTC_OFF_FLAGS, 8'h00);
    rdChk("flag", `GTC_OFF_FLAGS, 8'h00);
    $display("test overflow done");
    setCount(16'h0000);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h03);
    pm.pulses(5);
    repeat (8) @(posedge core_clk);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
    chkCount(16'h0004);
    sleepMode <= 1'b1;
    setCount(16'hFFFF);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h07);
    pm.pulses(3);
    repeat (4) @(posedge core_clk);
    chk("wake", 32'h1, {31'h0, wakeRequest});
    chkCount(16'h0001);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
    setCount(16'h0000);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h07);
    pm.pulses(1);
    pm.setLevel(1'b1);
    repeat (4) @(posedge core_clk);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
    pm.setLevel(1'b0);
    repeat (4) @(posedge core_clk);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h07);
    pm.pulses(2);
    repeat (4) @(posedge core_clk);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
    chkCount(16'h0002);
    setCount(16'h0000);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h0F);
    pm.lpPulses(3);
    repeat (4) @(posedge core_clk);
    xfer(1'b1, `GTC_OFF_CONTROL, 8'h00);
    chkCount(16'h0002);
    $display("test counter done");
    tallyAndFinish();
  end
endmodule // gtc_timer_tb_top
